// ==== design/crt_text_display_generator.sv ====
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
// Contract
// [R01] hsync at eightieth character count
// [R02] vsync while line count 24 to 26
// [R03] cpu address feeds ram during access
// [R04] cpu read returns addressed ram byte
// [R05] cpu write stores byte into ram
// [R06] glyph from character code and scan row
// [R07] one character pipeline, shift dots out
// [R08] blank retrace, cpu access, scans 8-9
// [R09] blank by disabling character generator
// [R10] video ram decoded at 3000-3fff
// [R11] 128 byte row stride, 80 columns shown
// [R12] scroll value offsets the line address
// [R13] screen row shows (s+23-offset) mod 24
// [R14] control bit 7 maps rom and video low
// [R15] video bank and low ram exclusive
// [R16] control bit 6 selects character set
// [R17] dot clock divided by seven, preload nine
// [R18] character clock divided by 128
// [R19] scan clock divided by ten
// [R20] line by 26 frame, frame by 16 blink
// [R21] access enable only in mapped window
// [R22] scroll holds value, rows wrap mod 24
module crt_text_display_generator (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic dotClockPin,
  input wire logic [15:0] cpuAddr,
  input wire logic [crt_pkg::VRAM_DATA_W-1:0] cpuDataIn,
  output logic [crt_pkg::VRAM_DATA_W-1:0] cpuDataOut,
  output logic cpuDataOe_b,
  input wire logic memReq_b,
  input wire logic ioReq_b,
  input wire logic rd_b,
  input wire logic wr_b,
  output logic cpuVideoAccessEnable_b,
  output logic romSelect_b,
  output logic lowRamEnable,
  output logic [7:0] systemControl,
  output logic hsync,
  output logic vsync,
  output logic serialVideo,
  output logic frameClock,
  output logic blinkClock
);
  import crt_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic dotMeta;
  logic dotSync;
  logic dotPrev;
  logic [15:0] addrMeta;
  logic [15:0] addrSync;
  logic [7:0] dataMeta;
  logic [7:0] dataSync;
  logic [3:0] strobeMeta;
  logic [3:0] strobeSync;

  // strobes idle high, so reset them inactive
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      dotMeta <= 1'b0;
      dotSync <= 1'b0;
      dotPrev <= 1'b0;
      addrMeta <= 16'h0000;
      addrSync <= 16'h0000;
      dataMeta <= 8'h00;
      dataSync <= 8'h00;
      strobeMeta <= 4'hf;
      strobeSync <= 4'hf;
    end else begin
      dotMeta <= dotClockPin;
      dotSync <= dotMeta;
      dotPrev <= dotSync;
      addrMeta <= cpuAddr;
      addrSync <= addrMeta;
      dataMeta <= cpuDataIn;
      dataSync <= dataMeta;
      strobeMeta <= {memReq_b, ioReq_b, rd_b, wr_b};
      strobeSync <= strobeMeta;
    end
  end

  // each bus bit is synced on its own, so a word is only
  // coherent once the pins have settled; hold address and
  // data steady for a few clocks ahead of the strobes
  wire dotTick = dotSync & ~dotPrev;
  wire memCycle = ~strobeSync[3];
  wire ioCycle = ~strobeSync[2];
  wire readStrobe = ~strobeSync[1];
  wire writeStrobe = ~strobeSync[0];

  //////////////////////////////////////////////////////////////////////////
  // address decode and bank switching

  logic [7:0] control;
  logic [7:0] scroll;

  wire bankLow = control[BANK_BIT];
  wire inLowBank = addrSync <= LOW_BANK_TOP;
  wire inVideoWindow = (addrSync >= VRAM_BASE) &&
                       (addrSync <= VRAM_TOP); // see [R10]
  wire videoAccess = memCycle & inVideoWindow & bankLow; // see [R21]
  wire romAccess = memCycle & inLowBank & ~inVideoWindow & bankLow; // see [R14]
  // program ram only when the low bank is switched away, see [R15]
  wire lowRamAccess = memCycle & inLowBank & ~bankLow; // see [R14]
  wire ctrlSel = ioCycle & (addrSync[7:0] == CTRL_PORT);
  wire scrollSel = ioCycle & (addrSync[7:0] == SCROLL_PORT);

  assign cpuVideoAccessEnable_b = ~videoAccess;
  assign romSelect_b = ~romAccess;
  assign lowRamEnable = lowRamAccess;
  assign systemControl = control;

  //////////////////////////////////////////////////////////////////////////
  // processor cycle sequencing

  cycle_state_t cycleState;
  cycle_state_t next_cycleState;

  wire cycleActive = (memCycle | ioCycle) & (readStrobe | writeStrobe);

  always_comb begin
    next_cycleState = cycleState;
    case (cycleState)
      CYCLE_IDLE: begin
        if (cycleActive && writeStrobe) begin
          next_cycleState = CYCLE_WRITE;
        end else if (cycleActive) begin
          next_cycleState = CYCLE_READ;
        end
      end
      CYCLE_READ: begin
        if (!cycleActive) begin
          next_cycleState = CYCLE_IDLE;
        end
      end
      CYCLE_WRITE: begin
        if (!cycleActive) begin
          next_cycleState = CYCLE_IDLE;
        end
      end
      default: begin
        next_cycleState = CYCLE_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cycleState <= CYCLE_IDLE;
    end else begin
      cycleState <= next_cycleState;
    end
  end

  // one write per cycle, taken as the state leaves idle
  // so a strobe held long never stores the byte twice
  wire writeOnce = (cycleState == CYCLE_IDLE) &&
                   (next_cycleState == CYCLE_WRITE);
  wire reading = (cycleState == CYCLE_READ);

  //////////////////////////////////////////////////////////////////////////
  // control port and scroll register

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      control <= CTRL_RESET;
      scroll <= SCROLL_RESET;
    end else begin
      if (writeOnce && ctrlSel) begin
        control <= dataSync;
      end
      if (writeOnce && scrollSel) begin
        scroll <= dataSync; // see [R12] [R22]
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // counter chain

  logic [3:0] dotCount;
  logic [6:0] charCount;
  logic [3:0] scanCount;
  logic [4:0] lineCount;
  logic [3:0] blinkCount;

  // preload of nine reaches fifteen after six dots, reloads on the seventh
  wire charTick = dotTick && (dotCount == DOT_TOP); // see [R17]
  wire scanTick = charTick && (charCount == CHAR_LAST); // see [R18]
  wire lineTick = scanTick && (scanCount == SCAN_LAST); // see [R19]
  wire frameTick = lineTick && (lineCount == LINE_LAST); // see [R20]
  // blink toggles every eight frames

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      dotCount <= DOT_PRELOAD;
      charCount <= 7'h00;
    end else if (dotTick) begin
      dotCount <= charTick ? DOT_PRELOAD : dotCount + 4'h1; // see [R17]
      if (charTick) begin
        charCount <= charCount + 7'h01; // see [R18]
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      scanCount <= 4'h0;
      lineCount <= 5'h00;
      blinkCount <= 4'h0;
    end else begin
      if (scanTick) begin
        scanCount <= lineTick ? 4'h0 : scanCount + 4'h1; // see [R19]
      end
      if (lineTick) begin
        lineCount <= frameTick ? 5'h00 : lineCount + 5'h01; // see [R20]
      end
      if (frameTick) begin
        blinkCount <= blinkCount + 4'h1; // see [R20]
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // display address with hardware scroll

  // only offset bits 4:0 count; offsets 24 to 31 wrap and act as 0 to 7
  wire [6:0] rowSum = {2'b00, lineCount} + ROW_BIAS -
                      {2'b00, scroll[ROW_W-1:0]}; // see [R12]
  wire [6:0] rowWrapped = (rowSum >= ROWS_TWICE) ? rowSum - ROWS_TWICE :
                          (rowSum >= ROWS_ONCE) ? rowSum - ROWS_ONCE :
                          rowSum; // see [R13] [R22]
  wire [VRAM_ADDR_W-1:0] displayAddr =
    {rowWrapped[ROW_W-1:0], charCount}; // see [R11]
  wire [VRAM_ADDR_W-1:0] ramAddr =
    videoAccess ? addrSync[VRAM_ADDR_W-1:0] : displayAddr; // see [R03]

  logic [VRAM_DATA_W-1:0] ramData;
  // display fetch loses the ram while the host holds it

  video_ram #(
    .ADDR_W(VRAM_ADDR_W),
    .DATA_W(VRAM_DATA_W)
  ) videoRam (
    .clock(clock),
    .writeEnable(writeOnce & videoAccess), // see [R05]
    .address(ramAddr),
    .writeData(dataSync),
    .readData(ramData)
  );

  //////////////////////////////////////////////////////////////////////////
  // processor read path

  // unmapped ports leave the transceivers facing the ram
  wire readDrive = reading & (videoAccess | ctrlSel | scrollSel);
  wire [7:0] readSel = videoAccess ? ramData :
                       ctrlSel ? control : scroll; // see [R04]

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cpuDataOut <= 8'h00;
    end else if (reading) begin
      cpuDataOut <= readSel; // see [R04]
    end
  end

  // transceivers face the ram unless a read of video ram, control or scroll is under way
  assign cpuDataOe_b = ~readDrive; // see [R04]

  //////////////////////////////////////////////////////////////////////////
  // character generator and dot pipeline

  // font contents are a stand-in pattern; bit 7 of a code marks blink
  function automatic logic [DOTS_W-1:0] glyph(
    input logic [7:0] code,
    input logic [3:0] row,
    input logic altSet,
    input logic blinkOff
  );
    logic [DOTS_W-1:0] pattern;
    pattern = code[DOTS_W-1:0] ^ {row[2:0], row};
    if (altSet) begin
      pattern = ~pattern;
    end
    if (code[7] && blinkOff) begin
      pattern = {DOTS_W{1'b0}};
    end
    return pattern;
  endfunction

  wire hBlank = charCount >= DISPLAY_COLS; // see [R08]
  wire vBlank = lineCount >= TEXT_ROWS; // see [R08]
  wire scanBlank = scanCount >= BLANK_SCAN; // see [R08]
  wire blank = hBlank | vBlank | videoAccess | scanBlank; // see [R08]
  wire [DOTS_W-1:0] glyphDots = glyph(ramData, scanCount,
                                      control[CHARSET_BIT],
                                      blinkCount[3]); // see [R06] [R16]
  // generator output disabled, stream itself is never gated
  wire [DOTS_W-1:0] genOut =
    blank ? {DOTS_W{1'b0}} : glyphDots; // see [R09]

  logic [DOTS_W-1:0] dotShift;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      dotShift <= {DOTS_W{1'b0}};
    end else if (charTick) begin
      dotShift <= genOut; // see [R07]
    end else if (dotTick) begin
      dotShift <= {dotShift[DOTS_W-2:0], 1'b0}; // see [R07]
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // sync and timing outputs
  // registered so the pins carry no decode glitches;
  // vsync spans lines 24 and 25, the frame wraps first

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      hsync <= 1'b0;
      vsync <= 1'b0;
      frameClock <= 1'b0;
      blinkClock <= 1'b0;
      serialVideo <= 1'b0;
    end else begin
      hsync <= charCount == HSYNC_COUNT; // see [R01]
      vsync <= (lineCount >= VSYNC_FIRST) &&
               (lineCount < VSYNC_END); // see [R02]
      frameClock <= frameTick;
      blinkClock <= blinkCount[3];
      serialVideo <= dotShift[DOTS_W-1]; // see [R07]
    end
  end

endmodule // crt_text_display_generator

// ==== common/crt_pkg.sv ====
package crt_pkg;

  // processor side decode
  localparam logic [15:0] VRAM_BASE = 16'h3000;
  localparam logic [15:0] VRAM_TOP = 16'h3fff;
  localparam logic [15:0] LOW_BANK_TOP = 16'h3fff;
  localparam logic [7:0] CTRL_PORT = 8'h1c;
  localparam logic [7:0] SCROLL_PORT = 8'h14;
  localparam int BANK_BIT = 7;
  localparam int CHARSET_BIT = 6;
  localparam logic [7:0] CTRL_RESET = 8'h80;
  localparam logic [7:0] SCROLL_RESET = 8'h17;

  // video ram geometry
  localparam int VRAM_ADDR_W = 12;
  localparam int VRAM_DATA_W = 8;
  localparam int ROW_W = 5;
  localparam int COL_W = 7;
  localparam int DOTS_W = 7;

  // counter chain
  localparam logic [3:0] DOT_PRELOAD = 4'h9;
  localparam logic [3:0] DOT_TOP = 4'hf;
  localparam logic [6:0] CHAR_LAST = 7'h7f;
  localparam logic [6:0] HSYNC_COUNT = 7'h50;
  localparam logic [6:0] DISPLAY_COLS = 7'h50;
  localparam logic [3:0] SCAN_LAST = 4'h9;
  localparam logic [3:0] BLANK_SCAN = 4'h8;
  localparam logic [4:0] LINE_LAST = 5'h19;
  localparam logic [4:0] TEXT_ROWS = 5'h18;
  localparam logic [4:0] VSYNC_FIRST = 5'h18;
  localparam logic [4:0] VSYNC_END = 5'h1a;
  localparam logic [3:0] BLINK_LAST = 4'hf;

  // scroll arithmetic: line + rows + 23 - offset, then modulo rows
  localparam logic [6:0] ROW_BIAS = 7'h2f;
  localparam logic [6:0] ROWS_ONCE = 7'h18;
  localparam logic [6:0] ROWS_TWICE = 7'h30;

  typedef enum logic [2:0] {
    CYCLE_IDLE = 3'b001,
    CYCLE_READ = 3'b010,
    CYCLE_WRITE = 3'b100
  } cycle_state_t;

endpackage

// ==== design/video_ram.sv ====
`timescale 1ns/1ps

module video_ram #(
  parameter int ADDR_W = crt_pkg::VRAM_ADDR_W,
  parameter int DATA_W = crt_pkg::VRAM_DATA_W
) (
  input wire logic clock,
  input wire logic writeEnable,
  input wire logic [ADDR_W-1:0] address,
  input wire logic [DATA_W-1:0] writeData,
  output logic [DATA_W-1:0] readData
);
  import crt_pkg::*;

  // plain flop array, contents undefined after power up
  logic [DATA_W-1:0] cells [0:(1<<ADDR_W)-1];

  always_ff @(posedge clock) begin
    if (writeEnable) begin
      cells[address] <= writeData;
    end
  end

  assign readData = cells[address];

endmodule // video_ram

// ==== test/crt_display_checker.sv ====
`timescale 1ns/1ps

module crt_display_checker (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic [15:0] cpuAddr,
  input wire logic memReq_b,
  input wire logic rd_b,
  input wire logic cpuDataOe_b,
  input wire logic cpuVideoAccessEnable_b,
  input wire logic romSelect_b,
  input wire logic lowRamEnable,
  input wire logic [7:0] systemControl,
  input wire logic hsync,
  input wire logic vsync,
  input wire logic serialVideo,
  input wire logic frameClock
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  // bench runs two clocks per dot, so one scan line is 1792 clocks
  logic [11:0] lineClks;
  logic lineSeen;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      lineClks <= 12'h000;
      lineSeen <= 1'b0;
    end else begin
      lineClks <= $rose(hsync) ? 12'h000 : lineClks + 12'h001;
      lineSeen <= lineSeen | $rose(hsync);
    end
  end
  sequence hsyncCharTime;
    hsync[*8] ##1 hsync[*6] ##1 !hsync;
  endsequence
  sequence blankCell;
    !serialVideo[*8];
  endsequence
  ////////////////////////////////////////
  chk_video_window: assert property (
    !cpuVideoAccessEnable_b |-> $past(cpuAddr[15:12], 2) == 4'h3
    && systemControl[7] && !($past(memReq_b, 2) && $past(memReq_b, 3)))
    else $error("video access outside its window");
  chk_read_drive: assert property (
    !cpuDataOe_b |-> !($past(rd_b, 2) && $past(rd_b, 3)))
    else $error("data bus driven without a read");
  chk_bank_excl: assert property (
    !(lowRamEnable && !cpuVideoAccessEnable_b))
    else $error("video and low ram enabled together");
  chk_lowram_bank: assert property (
    lowRamEnable |-> !systemControl[7])
    else $error("low ram enabled with bank bit set");
  chk_rom_bank: assert property (
    !romSelect_b |-> systemControl[7] && cpuVideoAccessEnable_b)
    else $error("rom select wrong");
  chk_hsync_width: assert property (
    $rose(hsync) |-> hsyncCharTime)
    else $error("hsync not one character time");
  chk_line_period: assert property (
    $rose(hsync) && lineSeen |-> lineClks == 12'h6ff)
    else $error("scan line length wrong");
  chk_retrace_blank: assert property (
    $fell(hsync) |-> ##2 blankCell)
    else $error("video lit in retrace");
  chk_vsync_blank: assert property (
    vsync |-> !serialVideo)
    else $error("video lit in vertical retrace");
  chk_frame_pulse: assert property (
    frameClock |=> !frameClock)
    else $error("frame pulse too long");
endmodule // crt_display_checker

bind crt_text_display_generator crt_display_checker chk (
  .clock(clock), .rst_b(rst_b), .cpuAddr(cpuAddr), .memReq_b(memReq_b),
  .rd_b(rd_b), .cpuDataOe_b(cpuDataOe_b),
  .cpuVideoAccessEnable_b(cpuVideoAccessEnable_b),
  .romSelect_b(romSelect_b), .lowRamEnable(lowRamEnable),
  .systemControl(systemControl), .hsync(hsync), .vsync(vsync),
  .serialVideo(serialVideo), .frameClock(frameClock)
);

// ==== test/cpu_host_model.sv ====
`timescale 1ns/1ps

module cpu_host_model (
  input wire logic clock,
  input wire logic [7:0] cpuDataOut,
  input wire logic cpuDataOe_b,
  output logic [15:0] cpuAddr,
  output logic [7:0] cpuDataIn,
  output logic memReq_b,
  output logic ioReq_b,
  output logic rd_b,
  output logic wr_b
);
  logic [7:0] hostData;
  // shared wire: device wins only while its drivers are on
  assign cpuDataIn = !cpuDataOe_b ? cpuDataOut : hostData;
  initial begin
    cpuAddr = 16'h0000;
    hostData = 8'h00;
    memReq_b = 1'b1;
    ioReq_b = 1'b1;
    rd_b = 1'b1;
    wr_b = 1'b1;
  end
  ////////////////////////////////////////
  task automatic cycle(input logic io, input logic rd, input logic [15:0] a,
                       input logic [7:0] d, output logic [7:0] q);
    int n;
    @(negedge clock);
    cpuAddr = a;
    hostData = d;
    // pins are synced per bit, so address settles well ahead
    repeat (3) @(negedge clock);
    memReq_b = io;
    ioReq_b = !io;
    rd_b = !rd;
    wr_b = rd;
    n = 0;
    while (rd && cpuDataOe_b !== 1'b0 && n < 20) begin
      @(negedge clock);
      n++;
    end
    repeat (4) @(negedge clock);
    q = cpuDataOut;
    memReq_b = 1'b1;
    ioReq_b = 1'b1;
    rd_b = 1'b1;
    wr_b = 1'b1;
    repeat (4) @(negedge clock);
    // released bus floats: show the inverse, not a stale value
    cpuAddr = ~a;
    hostData = ~d;
  endtask
endmodule // cpu_host_model

// ==== test/tb_crt_text_display_generator.sv ====
`timescale 1ns/1ps

module tb_crt_text_display_generator;
  import crt_pkg::*;
  logic clock, rst_b, dotClockPin, cpuDataOe_b, memReq_b, ioReq_b, rd_b;
  logic wr_b, cpuVideoAccessEnable_b, romSelect_b, lowRamEnable, hsync;
  logic vsync, serialVideo, frameClock, blinkClock;
  logic [15:0] cpuAddr;
  logic [7:0] cpuDataIn, cpuDataOut, systemControl, q;
  logic [31:0] seed = 32'h10;
  int failCount, checks, cycles, hsRises, sc;
  int vram [4096];
  crt_text_display_generator DUT (.clock(clock), .rst_b(rst_b),
    .dotClockPin(dotClockPin), .cpuAddr(cpuAddr), .cpuDataIn(cpuDataIn),
    .cpuDataOut(cpuDataOut), .cpuDataOe_b(cpuDataOe_b),
    .memReq_b(memReq_b), .ioReq_b(ioReq_b), .rd_b(rd_b), .wr_b(wr_b),
    .cpuVideoAccessEnable_b(cpuVideoAccessEnable_b),
    .romSelect_b(romSelect_b), .lowRamEnable(lowRamEnable),
    .systemControl(systemControl), .hsync(hsync), .vsync(vsync),
    .serialVideo(serialVideo), .frameClock(frameClock),
    .blinkClock(blinkClock));
  cpu_host_model host (.clock(clock), .cpuDataOut(cpuDataOut),
    .cpuDataOe_b(cpuDataOe_b), .cpuAddr(cpuAddr), .cpuDataIn(cpuDataIn),
    .memReq_b(memReq_b), .ioReq_b(ioReq_b), .rd_b(rd_b), .wr_b(wr_b));
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // two clocks per dot keeps a scan line short enough to watch
  initial begin
    dotClockPin = 1'b0;
    forever #4 dotClockPin = ~dotClockPin;
  end
  always @(posedge hsync) hsRises++;
  always @(posedge clock) begin
    cycles++;
    if (cycles == 100000) begin
      failCount++;
      closeOut();
    end
  end
  ////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      failCount++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic closeOut();
    $display("checks %0d mismatches %0d", checks, failCount);
    if (failCount == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // lit clocks over one scan line, edges padded into blank cells
  task automatic measure(input int scroll, input logic alt);
    int n, j, t, row, m, g, e, v, code;
    @(negedge hsync);
    repeat (4) @(posedge clock);
    j = hsRises;
    t = (j / 10) % 26;
    row = j % 10;
    m = (t + 23 - scroll) % 24;
    n = 0;
    e = 0;
    v = 0;
    // an unknown dot counts as lit so it cannot slip through
    while (hsync !== 1'b1) begin
      @(posedge clock);
      n += int'(serialVideo !== 1'b0);
      v |= int'(vsync !== 1'b0 || frameClock !== 1'b0);
    end
    repeat (18) begin
      @(posedge clock);
      n += int'(serialVideo !== 1'b0);
    end
    for (int c = 0; c < 80; c++) begin
      code = vram[m * 128 + c];
      g = (code ^ (((row & 7) << 4) | row)) & 32'h7f;
      if (alt) g = ~g & 32'h7f;
      if (code[7] && blinkClock) g = 0;
      if (row < 8 && t < 24) e += $countones(g);
    end
    check("lit dots", 32'(2 * e), 32'(n));
    check("vertical idle", 32'h0, 32'(v));
    $display("test display line %0d done", j);
  endtask
  ////////////////////////////////////////
  initial begin
    int a;
    int probe[5];
    probe = '{0, 79, 128, 3023, 4095};
    rst_b = 1'b0;
    repeat (5) @(negedge clock);
    rst_b = 1'b1;
    check("control reset", 32'(CTRL_RESET), 32'(systemControl));
    check("drive idle", 32'h1, 32'(cpuDataOe_b));
    check("blink idle", 32'h0, 32'(blinkClock));
    host.cycle(1'b1, 1'b1, 16'h001c, 8'h00, q);
    check("control read", 32'h80, 32'(q));
    host.cycle(1'b1, 1'b1, 16'h0014, 8'h00, q);
    check("scroll read", 32'h17, 32'(q));
    $display("test reset done");
    // full byte codes set bit 7, though blinkClock stays low for the whole run
    for (int r = 0; r < 24; r++) begin
      for (int c = 0; c < 80; c++) begin
        a = r * 128 + c;
        vram[a] = rnd() & 32'hff;
        host.cycle(1'b0, 1'b0, 16'h3000 + 16'(a), 8'(vram[a]),
                   q);
      end
    end
    vram[4095] = 32'h5a;
    host.cycle(1'b0, 1'b0, 16'h3fff, 8'h5a, q);
    host.cycle(1'b0, 1'b0, 16'h2fff, 8'ha5, q);
    host.cycle(1'b0, 1'b0, 16'h4000, 8'ha5, q);
    foreach (probe[i]) begin
      host.cycle(1'b0, 1'b1, 16'h3000 + 16'(probe[i]), 8'h00,
                 q);
      check("video read", 32'(vram[probe[i]]), 32'(q));
    end
    $display("test video access done");
    host.cycle(1'b1, 1'b0, 16'h001c, 8'h00, q);
    check("control write", 32'h0, 32'(systemControl));
    host.cycle(1'b0, 1'b0, 16'h3000, 8'hff, q);
    host.cycle(1'b1, 1'b0, 16'h001c, 8'h80, q);
    host.cycle(1'b0, 1'b1, 16'h3000, 8'h00, q);
    check("bank isolation", 32'(vram[0]), 32'(q));
    $display("test bank done");
    repeat (4) measure(23, 1'b0);
    sc = rnd() % 24;
    host.cycle(1'b1, 1'b0, 16'h0014, 8'(sc), q);
    host.cycle(1'b1, 1'b0, 16'h001c, 8'hc0, q);
    host.cycle(1'b1, 1'b1, 16'h0014, 8'h00, q);
    check("scroll hold", 32'(sc), 32'(q));
    repeat (6) measure(sc, 1'b1);
    closeOut();
  end
endmodule // tb_crt_text_display_generator
